// [core/spmsp_top.sv]
`timescale 1ns/1ps
module spmsp_top #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire spmsp_pkg::spmsp_sense_t pin_in,
    input wire spmsp_pkg::spmsp_dir_t pin_dir,
    output spmsp_pkg::spmsp_drive_t pin_out,
    output spmsp_pkg::spmsp_drive_t pin_oe,
    // interrupt
    input wire logic global_irq_en,
    input wire logic irq_vector_taken,
    output logic irq
);

    logic [7:0] ctrl_q;
    logic double_q;
    logic done_q;
    logic write_collision_flag_q;
    logic arm_done_q;
    logic arm_write_collision_flag_q;
    logic [7:0] rxbuf_q;
    logic [7:0] tx_sh_q;
    logic [7:0] tx_sh_d;
    logic [7:0] rx_sh_q;
    logic [7:0] rx_next;
    logic [3:0] bit_cnt_q;
    logic [4:0] edge_cnt_q;
    logic [6:0] div_cnt_q;
    logic [6:0] half_m1;
    logic sck_prev_q;
    spmsp_pkg::spmsp_state_t state_q;
    logic sck_q;
    logic mosi_q;
    logic miso_q;
    spmsp_pkg::spmsp_drive_t oe_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    logic port_en;
    logic master;
    logic order_lsb;
    logic idle_lvl;
    logic phase;
    logic acc_end;
    logic acc_mid;
    logic hit_ctrl;
    logic hit_status;
    logic hit_data;
    logic data_wr;
    logic data_acc;
    logic status_rd;
    logic mode_fault;
    logic m_run;
    logic m_tick;
    logic m_lead;
    logic m_end;
    logic slave_act;
    logic s_edge;
    logic s_lead;
    logic any_edge;
    logic lead;
    logic sample;
    logic setup;
    logic rx_in;
    logic busy;
    logic load;
    logic start;
    logic byte_done;
    logic done_set;
    logic done_clr;
    logic write_collision_flag_clr;
    logic tx_bit;

    // sck half period minus one for the selected rate
    function automatic logic [6:0] half_minus_one(input logic [1:0] rate,
                                                  input logic dbl);
        logic [6:0] h;
        h = spmsp_pkg::HALF_RATE0;
        unique case (rate)
            2'b00: h = spmsp_pkg::HALF_RATE0;
            2'b01: h = spmsp_pkg::HALF_RATE1;
            2'b10: h = spmsp_pkg::HALF_RATE2;
            2'b11: h = spmsp_pkg::HALF_RATE3;
        endcase
        if (dbl) begin
            h = h >> 1;
        end
        return h - 7'h01;
    endfunction

    // control field decode
    assign port_en = ctrl_q[spmsp_pkg::CTRL_PORT_EN_BIT];
    assign master = ctrl_q[spmsp_pkg::CTRL_MASTER_BIT];
    assign order_lsb = ctrl_q[spmsp_pkg::CTRL_ORDER_BIT];
    assign idle_lvl = ctrl_q[spmsp_pkg::CTRL_IDLE_LVL_BIT];
    assign phase = ctrl_q[spmsp_pkg::CTRL_PHASE_BIT];
    assign half_m1 = half_minus_one(
        {ctrl_q[spmsp_pkg::CTRL_RATE_HI_BIT],
         ctrl_q[spmsp_pkg::CTRL_RATE_LO_BIT]}, double_q);

    // apb decode
    assign acc_mid = psel & penable & ~pready_q;
    assign acc_end = psel & penable & pready_q;
    assign hit_ctrl = paddr == ADDR_W'(spmsp_pkg::CTRL_OFFSET);
    assign hit_status = paddr == ADDR_W'(spmsp_pkg::STATUS_OFFSET);
    assign hit_data = paddr == ADDR_W'(spmsp_pkg::DATA_OFFSET);
    assign data_wr = acc_end & pwrite & hit_data;
    assign data_acc = acc_end & hit_data;
    assign status_rd = acc_end & ~pwrite & hit_status;

    // select input low while master with select as input
    assign mode_fault = port_en & master & ~pin_dir.ss & ~pin_in.ss_n;

    // master clock generator
    assign m_run = state_q == spmsp_pkg::SPMSP_RUN;
    assign m_tick = m_run & (div_cnt_q == half_m1);
    assign m_lead = m_tick & ~edge_cnt_q[0];
    assign m_end = m_tick & (edge_cnt_q == spmsp_pkg::LAST_EDGE);

    // slave edge detection on sampled sck
    assign slave_act = port_en & ~master & ~pin_in.ss_n;
    assign s_edge = slave_act & (pin_in.sck != sck_prev_q);
    assign s_lead = s_edge & (pin_in.sck != idle_lvl);

    // common edge roles
    assign any_edge = m_tick | s_edge;
    assign lead = m_lead | s_lead;
    assign sample = any_edge & (lead != phase);
    assign setup = any_edge & ~sample;
    assign rx_in = master ? pin_in.miso : pin_in.mosi;
    assign rx_next = order_lsb ? {rx_in, rx_sh_q[7:1]}
                               : {rx_sh_q[6:0], rx_in};
    assign byte_done = sample & (bit_cnt_q == spmsp_pkg::LAST_BIT);

    // data register write handling
    assign busy = m_run | (~master & (bit_cnt_q != 4'h0));
    assign load = data_wr & ~busy & port_en;
    assign start = load & master & ~mode_fault;

    // flag set and clear terms
    assign done_set = (master ? m_end : byte_done) | mode_fault;
    assign done_clr = irq_vector_taken
                    | (data_acc & (arm_done_q | arm_write_collision_flag_q));
    assign write_collision_flag_clr = data_acc & arm_write_collision_flag_q;

    // transmit shifter next value
    always_comb begin
        tx_sh_d = tx_sh_q;
        if (load) begin
            tx_sh_d = pwdata[7:0];
        end else if (setup & (bit_cnt_q != 4'h0)) begin
            if (order_lsb) begin
                tx_sh_d = {1'b0, tx_sh_q[7:1]};
            end else begin
                tx_sh_d = {tx_sh_q[6:0], 1'b0};
            end
        end
        tx_bit = order_lsb ? tx_sh_d[0] : tx_sh_d[7];
    end

    // control register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= spmsp_pkg::CTRL_RESET;
        end else begin
            if (acc_end & pwrite & hit_ctrl) begin
                ctrl_q <= pwdata[7:0];
            end
            if (mode_fault) begin
                ctrl_q[spmsp_pkg::CTRL_MASTER_BIT] <= 1'b0;
            end
        end
    end

    // double rate bit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            double_q <= spmsp_pkg::STATUS_RESET[spmsp_pkg::STATUS_DOUBLE_BIT];
        end else if (acc_end & pwrite & hit_status) begin
            double_q <= pwdata[spmsp_pkg::STATUS_DOUBLE_BIT];
        end
    end

    // transfer done flag, set wins over clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            done_q <= spmsp_pkg::STATUS_RESET[spmsp_pkg::STATUS_DONE_BIT];
        end else begin
            done_q <= done_set | (done_q & ~done_clr);
        end
    end

    // write collision flag, set wins over clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            write_collision_flag_q <= spmsp_pkg::STATUS_RESET[spmsp_pkg::STATUS_WRITE_COLLISION_FLAG_BIT];
        end else begin
            write_collision_flag_q <= (data_wr & busy) | (write_collision_flag_q & ~write_collision_flag_clr);
        end
    end

    // status read arms the clear sequence
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            arm_done_q <= 1'b0;
            arm_write_collision_flag_q <= 1'b0;
        end else if (status_rd) begin
            arm_done_q <= done_q;
            arm_write_collision_flag_q <= write_collision_flag_q;
        end else if (data_acc) begin
            arm_done_q <= 1'b0;
            arm_write_collision_flag_q <= 1'b0;
        end
    end

    // master state and divider
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= spmsp_pkg::SPMSP_IDLE;
            div_cnt_q <= 7'h00;
            edge_cnt_q <= 5'h00;
            sck_q <= 1'b0;
        end else begin
            unique case (state_q)
                spmsp_pkg::SPMSP_IDLE: begin
                    sck_q <= idle_lvl;
                    div_cnt_q <= 7'h00;
                    edge_cnt_q <= 5'h00;
                    if (start) begin
                        state_q <= spmsp_pkg::SPMSP_RUN;
                    end
                end
                spmsp_pkg::SPMSP_RUN: begin
                    if (mode_fault | ~port_en | ~master) begin
                        state_q <= spmsp_pkg::SPMSP_IDLE;
                        sck_q <= idle_lvl;
                    end else if (m_tick) begin
                        div_cnt_q <= 7'h00;
                        sck_q <= ~sck_q;
                        edge_cnt_q <= edge_cnt_q + 5'h01;
                        if (m_end) begin
                            state_q <= spmsp_pkg::SPMSP_IDLE;
                        end
                    end else begin
                        div_cnt_q <= div_cnt_q + 7'h01;
                    end
                end
            endcase
        end
    end

    // bit counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_q <= 4'h0;
        end else if (~port_en | (~master & pin_in.ss_n)) begin
            bit_cnt_q <= 4'h0;
        end else if (start | mode_fault) begin
            bit_cnt_q <= 4'h0;
        end else if (byte_done) begin
            bit_cnt_q <= 4'h0;
        end else if (sample) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // receive shifter and receive buffer
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_sh_q <= spmsp_pkg::DATA_RESET;
            rxbuf_q <= spmsp_pkg::DATA_RESET;
        end else begin
            if (~master & pin_in.ss_n) begin
                rx_sh_q <= spmsp_pkg::DATA_RESET;
            end else if (sample) begin
                rx_sh_q <= rx_next;
            end
            if (byte_done) begin
                rxbuf_q <= rx_next;
            end
        end
    end

    // transmit shifter and data pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_sh_q <= spmsp_pkg::DATA_RESET;
            mosi_q <= 1'b0;
            miso_q <= 1'b0;
        end else begin
            tx_sh_q <= tx_sh_d;
            mosi_q <= tx_bit;
            miso_q <= tx_bit;
        end
    end

    // pin drive enables
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            oe_q <= '0;
            sck_prev_q <= 1'b0;
        end else begin
            oe_q.sck <= port_en & master & ~mode_fault & pin_dir.sck;
            oe_q.mosi <= port_en & master & ~mode_fault & pin_dir.mosi;
            oe_q.miso <= slave_act & pin_dir.miso;
            sck_prev_q <= pin_in.sck;
        end
    end

    // interrupt request
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ctrl_q[spmsp_pkg::CTRL_IRQ_EN_BIT] & done_q
                   & global_irq_en;
        end
    end

    // apb response, one wait state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc_mid;
            pslverr_q <= acc_mid & ~(hit_ctrl | hit_status | hit_data);
            if (acc_mid & ~pwrite) begin
                if (hit_ctrl) begin
                    prdata_q <= {24'h00_0000, ctrl_q};
                end else if (hit_status) begin
                    prdata_q <= {24'h00_0000, done_q, write_collision_flag_q, 5'h00,
                                 double_q};
                end else if (hit_data) begin
                    prdata_q <= {24'h00_0000, rxbuf_q};
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pin_out = {sck_q, mosi_q, miso_q};
    assign pin_oe = oe_q;
    assign irq = irq_q;

endmodule

// [core/spmsp_pkg.sv]
package spmsp_pkg;

    // register byte offsets
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] DATA_OFFSET = 12'h008;

    // serial_port_control fields
    localparam int CTRL_IRQ_EN_BIT = 7;
    localparam int CTRL_PORT_EN_BIT = 6;
    localparam int CTRL_ORDER_BIT = 5;
    localparam int CTRL_MASTER_BIT = 4;
    localparam int CTRL_IDLE_LVL_BIT = 3;
    localparam int CTRL_PHASE_BIT = 2;
    localparam int CTRL_RATE_HI_BIT = 1;
    localparam int CTRL_RATE_LO_BIT = 0;

    // serial_port_status fields
    localparam int STATUS_DONE_BIT = 7;
    localparam int STATUS_WRITE_COLLISION_FLAG_BIT = 6;
    localparam int STATUS_DOUBLE_BIT = 0;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // half periods of sck in clk_sys cycles, normal rate
    localparam logic [6:0] HALF_RATE0 = 7'h02;
    localparam logic [6:0] HALF_RATE1 = 7'h08;
    localparam logic [6:0] HALF_RATE2 = 7'h20;
    localparam logic [6:0] HALF_RATE3 = 7'h40;

    // byte framing
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [4:0] LAST_EDGE = 5'h0f;

    typedef enum logic [1:0] {
        SPMSP_IDLE = 2'b01,
        SPMSP_RUN = 2'b10
    } spmsp_state_t;

    // pin levels driven by the port
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
    } spmsp_drive_t;

    // pin levels seen by the port
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } spmsp_sense_t;

    // software pin directions, one means output
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss;
    } spmsp_dir_t;

endpackage

// [tb/spmsp_asserts.sv]
`timescale 1ns/1ps
// port checks
module spmsp_asserts #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire spmsp_pkg::spmsp_sense_t pin_in,
    input wire spmsp_pkg::spmsp_dir_t pin_dir,
    input wire spmsp_pkg::spmsp_drive_t pin_out,
    input wire spmsp_pkg::spmsp_drive_t pin_oe,
    // interrupt
    input wire logic global_irq_en,
    input wire logic irq_vector_taken,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_pready_one_wait: assert property (psel && $rose(penable)
        |-> !pready ##1 pready) else $error("pready not one wait");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero");
    a_status_rsvd_zero: assert property (
        pready && !pwrite && paddr == ADDR_W'(spmsp_pkg::STATUS_OFFSET)
        |-> prdata[5:1] == 5'h00) else $error("reserved bits set");
    a_deselect_miso_off: assert property (
        pin_in.ss_n [*4] |-> !pin_oe.miso) else $error("miso driven");
    a_fault_sck_off: assert property (
        pin_oe.sck && !pin_dir.ss && !pin_in.ss_n |-> ##[1:4] !pin_oe.sck)
        else $error("sck held after fault");
    a_role_one_side: assert property (
        !(pin_oe.sck && pin_oe.miso)) else $error("both roles drive");
    a_irq_global_off: assert property (
        !global_irq_en |=> !irq) else $error("irq without global");
    a_vector_irq_clear: assert property (
        irq_vector_taken |-> ##[1:3] !irq) else $error("irq kept");
endmodule

// [tb/spmsp_peer.sv]
`timescale 1ns/1ps
// serial peripheral beyond the port
module spmsp_peer (
    // clock
    input wire logic clk_sys,
    // pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    // frame setup
    input wire logic pol,
    input wire logic pha,
    input wire logic lsb,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_q
);
    logic sck_q = 1'b0;
    logic junk_q = 1'b0;
    logic [2:0] smp_q = 3'h0;
    logic [2:0] set_q = 3'h0;
    logic [2:0] idx;
    // next outgoing bit
    assign idx = pha ? set_q - 3'h1 : set_q;
    // released line keeps changing
    assign miso = ss_n ? junk_q : tx_byte[lsb ? idx : 3'h7 - idx];
    always_ff @(posedge clk_sys) begin
        sck_q <= sck;
        junk_q <= ~junk_q;
        if (ss_n) begin
            smp_q <= 3'h0;
            set_q <= 3'h0;
        end else if (sck != sck_q) begin
            if ((sck != pol) ^ pha) begin
                rx_q[lsb ? smp_q : 3'h7 - smp_q] <= mosi;
                smp_q <= smp_q + 3'h1;
            end else begin
                set_q <= set_q + 3'h1;
            end
        end
    end
endmodule

// [tb/test_spi_master_slave_port.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_spi_master_slave_port;
    localparam logic [11:0] AC = spmsp_pkg::CTRL_OFFSET;
    localparam logic [11:0] AS = spmsp_pkg::STATUS_OFFSET;
    localparam logic [11:0] AD = spmsp_pkg::DATA_OFFSET;
    logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rq;
    logic pready, pslverr, re, irq, global_irq_en = 0;
    logic irq_vector_taken = 0, ss_n = 1, ext_sck = 0, ext_mosi = 0;
    logic drv = 0, pol = 0, pha = 0, lsb = 0, peer_miso, sck_d;
    logic [7:0] peer_tx = 0, peer_rx, got;
    spmsp_pkg::spmsp_sense_t pin_in;
    spmsp_pkg::spmsp_dir_t pin_dir = 4'b1101;
    spmsp_pkg::spmsp_drive_t pin_out, pin_oe;
    int n_fail = 0, num_checks = 0, cnt = 0, gap = 0;
    assign pin_in = {pin_oe.sck ? pin_out.sck : ext_sck,
        pin_oe.mosi ? pin_out.mosi : ext_mosi,
        pin_oe.miso ? pin_out.miso : peer_miso, ss_n};
    spmsp_top dut_u (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_dir, .pin_out,
        .pin_oe, .global_irq_en, .irq_vector_taken, .irq);
    spmsp_peer peer_u (.clk_sys, .sck(pin_in.sck), .mosi(pin_in.mosi),
        .ss_n, .miso(peer_miso), .pol, .pha, .lsb, .tx_byte(peer_tx),
        .rx_q(peer_rx));
    initial forever #4 clk_sys = ~clk_sys;
    // sck half period and idle data line
    always @(posedge clk_sys) begin
        sck_d <= pin_out.sck;
        cnt <= (pin_out.sck !== sck_d) ? 1 : cnt + 1;
        if (pin_out.sck !== sck_d) gap <= cnt;
        if (!drv) ext_mosi <= ~ext_mosi;
    end
    function automatic int half(input logic [1:0] r, input logic x);
        int dv[4] = '{4, 16, 64, 128};
        return x ? dv[r] / 4 : dv[r] / 2;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(0, AS, 0);
            n++;
        end while (rq[7] !== 1'b1 && n < 400);
        `CHK("done wait", 1'b1, rq[7])
    endtask
    // external master, mode 0, msb first, clk/8
    task automatic sl_clk(input logic [7:0] d, input int nb);
        drv <= 1;
        @(posedge clk_sys);
        for (int b = 0; b < nb; b++) begin
            ext_mosi <= d[7 - b];
            repeat (4) @(posedge clk_sys);
            ext_sck <= 1;
            got[7 - b] = pin_out.miso;
            repeat (4) @(posedge clk_sys);
            ext_sck <= 0;
        end
        repeat (4) @(posedge clk_sys);
        drv <= 0;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(26));
        repeat (8) @(posedge clk_sys);
        reset_n <= 1;
        @(posedge clk_sys);
        apb(0, AC, 0);
        `CHK("ctrl reset", 8'h00, rq[7:0])
        apb(0, AS, 0);
        `CHK("status reset", 8'h00, rq[7:0])
        apb(0, 12'h00C, 0);
        `CHK("unmapped", 33'h1_0000_0000, {re, rq})
        for (int i = 0; i < 8; i++) begin
            logic [7:0] d;
            d = 8'($urandom);
            ss_n <= 1;
            pol <= i[0] ^ i[2];
            pha <= i[1];
            lsb <= 1'($urandom);
            peer_tx <= 8'($urandom);
            @(posedge clk_sys);
            apb(1, AC, {2'b01, lsb, 1'b1, pol, pha, i[1:0]});
            apb(1, AS, {7'h00, i[2]});
            `CHK("idle sck", pol, pin_out.sck)
            ss_n <= 0;
            apb(1, AD, d);
            wait_done();
            `CHK("status", {1'b1, 6'h00, i[2]}, rq[7:0])
            `CHK("half period", half(i[1:0], i[2]), gap)
            `CHK("peer rx", d, peer_rx)
            apb(0, AD, 0);
            if (i != 4) `CHK("rx byte", peer_tx, rq[7:0])
            apb(0, AS, 0);
            `CHK("done clear", {7'h00, i[2]}, rq[7:0])
        end
        apb(1, AD, 8'hA5);
        apb(1, AD, 8'h5A);
        wait_done();
        `CHK("collision", 8'hC1, rq[7:0])
        `CHK("dropped", 8'hA5, peer_rx)
        apb(0, AD, 0);
        apb(0, AS, 0);
        `CHK("flags clear", 8'h01, rq[7:0])
        $display("test master done");
        ss_n <= 1;
        apb(1, AC, 8'h10);
        apb(1, AD, 8'h3C);
        repeat (100) @(posedge clk_sys);
        apb(0, AS, 0);
        `CHK("disabled", 8'h01, rq[7:0])
        pin_dir <= 4'b1100;
        apb(1, AC, 8'h50);
        ss_n <= 0;
        repeat (8) @(posedge clk_sys);
        ss_n <= 1;
        apb(0, AC, 0);
        `CHK("master lost", 8'h40, rq[7:0])
        `CHK("sck free", 1'b0, pin_oe.sck)
        apb(0, AS, 0);
        `CHK("fault done", 8'h81, rq[7:0])
        apb(1, AC, 8'hC0);
        global_irq_en <= 1;
        repeat (3) @(posedge clk_sys);
        `CHK("irq on", 1'b1, irq)
        irq_vector_taken <= 1;
        @(posedge clk_sys);
        irq_vector_taken <= 0;
        repeat (3) @(posedge clk_sys);
        apb(0, AS, 0);
        `CHK("vector clear", 8'h01, rq[7:0])
        $display("test fault and irq done");
        pin_dir <= 4'b0010;
        apb(1, AC, 8'h43);
        apb(1, AD, 8'h96);
        ss_n <= 0;
        repeat (4) @(posedge clk_sys);
        `CHK("miso on", 1'b1, pin_oe.miso)
        sl_clk(8'h3B, 8);
        `CHK("slave tx", 8'h96, got)
        wait_done();
        apb(0, AD, 0);
        `CHK("slave rx", 8'h3B, rq[7:0])
        ss_n <= 1;
        sl_clk(8'hE7, 8);
        `CHK("miso off", 1'b0, pin_oe.miso)
        apb(0, AS, 0);
        `CHK("no rx", 8'h01, rq[7:0])
        ss_n <= 0;
        sl_clk(8'hFF, 3);
        ss_n <= 1;
        apb(0, AD, 0);
        `CHK("rx kept", 8'h3B, rq[7:0])
        ss_n <= 0;
        sl_clk(8'h61, 8);
        wait_done();
        apb(0, AD, 0);
        `CHK("resync rx", 8'h61, rq[7:0])
        $display("test slave done");
        close_out();
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        close_out();
    end
endmodule
bind spmsp_top spmsp_asserts #(.ADDR_W(ADDR_W)) chk_u (.clk_sys, .reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_in, .pin_dir, .pin_out, .pin_oe, .global_irq_en,
    .irq_vector_taken, .irq);
